// File: bench/lpc_cmd_frames_properties.sv
// Purpose: Port assertions for the frame interpreter
// Assumes: One clock domain
// Notes:   Bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module lpc_chk (
	input wire logic        i_mclk,
	input wire logic        i_nrst,
	input wire logic        i_rx_valid,
	input wire logic        o_rsp_valid,
	input wire logic [7:0]  o_rsp_id,
	input wire logic [7:0]  o_rsp_type,
	input wire logic [15:0] o_rsp_name,
	input wire logic        o_err_valid,
	input wire logic        o_other_frame,
	input wire logic [31:0] o_rate_live,
	input wire logic [31:0] o_join_live,
	input wire logic        o_rate_115200
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	sequence s_queued;
		o_rsp_valid && o_rsp_type == 8'h09 && o_rsp_name != 16'h4143;
	endsequence
	sequence s_pulse;
		o_rsp_valid || o_err_valid || o_other_frame;
	endsequence
	a_rate_flag: assert property (o_rate_115200 == (o_rate_live == 32'h7))
		else $error("rate flag wrong");
	a_zero_id_quiet: assert property (o_rsp_valid |-> o_rsp_id != 8'h00)
		else $error("response for id zero");
	a_type_known: assert property (o_rsp_valid |-> o_rsp_type inside {8'h08, 8'h09})
		else $error("response for other type");
	a_queue_holds: assert property (s_queued |=> $stable(o_rate_live) && $stable(o_join_live))
		else $error("queued write took effect");
	a_other_no_change: assert property (o_other_frame |=> $stable(o_rate_live))
		else $error("other frame changed rate");
	a_pulse_after_byte: assert property (s_pulse |-> $past(i_rx_valid))
		else $error("pulse without byte");
	a_err_single: assert property (o_err_valid |=> !o_err_valid)
		else $error("error pulse too long");
	a_err_no_rsp: assert property (o_err_valid |-> !o_rsp_valid && !o_other_frame)
		else $error("error with response");
endmodule // lpc_chk
`default_nettype wire

// File: bench/lpc_host.sv
// Purpose: Host model sending command frames
// Assumes: One byte per clock while sending
// Notes:   Idle data line shows the inverted last byte
`timescale 1ns/1ps
`default_nettype none
module lpc_host (
	input  wire logic       i_mclk,
	output var  logic       o_valid,
	output var  logic [7:0] o_data
);
	initial begin
		o_valid = 1'b0;
		o_data  = 8'h00;
	end
	task automatic put(input logic [7:0] b);
		@(posedge i_mclk);
		o_valid <= 1'b1;
		o_data  <= b;
	endtask
	// Drops the strobe and shows the inverted last byte
	task automatic idle();
		@(posedge i_mclk);
		o_valid <= 1'b0;
		o_data  <= ~o_data;
	endtask
	// Sends n value bytes; bad flips checksum bits
	task automatic frame(input logic [7:0] t, id, input logic [15:0] nm,
		input logic [31:0] v, input int n, input logic [7:0] bad);
		logic [7:0] s;
		s = t + id + nm[15:8] + nm[7:0];
		put(8'h7e);
		put(8'h00);
		put(8'(4 + n));
		put(t);
		put(id);
		put(nm[15:8]);
		put(nm[7:0]);
		for (int i = n - 1; i >= 0; i--) begin
			put(v[8*i +: 8]);
			s = s + v[8*i +: 8];
		end
		put((8'hff - s) ^ bad);
		idle();
	endtask
endmodule // lpc_host
`default_nettype wire

// File: bench/tb.sv
// Purpose: Self-checking bench for the frame interpreter
// Assumes: Host model drives the byte stream
// Notes:   Table rows first, then hand-written cases
`timescale 1ns/1ps
`default_nettype none
`include "lpc_regs.vh"
module tb;
	typedef struct {logic [7:0] t, id; logic [15:0] nm; logic [31:0] v; int n;
		logic rsp, cv; logic [31:0] val, rate;} lpc_row_t;
	logic        i_mclk, i_nrst, i_rx_valid, o_rsp_valid, o_err_valid, o_other_frame;
	logic        o_rate_115200;
	logic [7:0]  i_rx_data, o_rsp_id, o_rsp_type, o_rsp_status, o_err_status;
	logic [15:0] o_rsp_name;
	logic [31:0] o_rsp_value, o_rate_live, o_join_live;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	lpc_row_t    rows [8];
	lpc_host i_host (.i_mclk(i_mclk), .o_valid(i_rx_valid), .o_data(i_rx_data));
	lpc_cmd_frames #(.MAX_LEN(16)) i_dut (.i_mclk(i_mclk), .i_nrst(i_nrst),
		.i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .o_rsp_valid(o_rsp_valid),
		.o_rsp_id(o_rsp_id), .o_rsp_type(o_rsp_type), .o_rsp_name(o_rsp_name),
		.o_rsp_status(o_rsp_status), .o_rsp_value(o_rsp_value), .o_err_valid(o_err_valid),
		.o_err_status(o_err_status), .o_other_frame(o_other_frame),
		.o_rate_live(o_rate_live), .o_join_live(o_join_live), .o_rate_115200(o_rate_115200));
	task automatic chk(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	initial begin
		#20000;
		n_mismatch++;
		final_report();
	end
	initial begin
		rows = '{'{8'h09, 8'h01, `LPC_NAME_RATE, 32'h7, 1, 1, 1, 32'h0, 32'h3},
			'{8'h09, 8'h02, `LPC_NAME_RATE, 32'h0, 0, 1, 1, 32'h3, 32'h3},
			'{8'h08, 8'h03, `LPC_NAME_JOIN, 32'h0, 0, 1, 1, 32'hff, 32'h7},
			'{8'h09, 8'h04, `LPC_NAME_RATE, 32'h3, 2, 1, 1, 32'h0, 32'h7},
			'{8'h09, 8'h05, `LPC_NAME_APPLY, 32'h0, 0, 1, 0, 32'h0, 32'h3},
			'{8'h08, 8'h06, `LPC_NAME_RATE, 32'h7, 4, 1, 1, 32'h0, 32'h7},
			'{8'h08, 8'h00, `LPC_NAME_RATE, 32'h3, 1, 0, 0, 32'h0, 32'h3},
			'{8'h10, 8'h07, `LPC_NAME_RATE, 32'h7, 1, 0, 0, 32'h0, 32'h3}};
		i_nrst = 1'b0;
		repeat (5) @(posedge i_mclk);
		i_nrst <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			i_host.frame(rows[k].t, rows[k].id, rows[k].nm, rows[k].v, rows[k].n, 8'h00);
			#1;
			chk(32'(o_rsp_valid), 32'(rows[k].rsp));
			if (rows[k].rsp) chk(32'(o_rsp_id), 32'(rows[k].id));
			if (rows[k].cv) chk(o_rsp_value, rows[k].val);
			if (rows[k].rsp) chk(32'(o_rsp_type), 32'(rows[k].t));
			if (rows[k].rsp) chk(32'(o_rsp_name), 32'(rows[k].nm));
			if (rows[k].rsp) chk(32'(o_rsp_status), 32'(`LPC_ST_OK));
			chk(32'(o_other_frame), 32'(rows[k].t != 8'h08 && rows[k].t != 8'h09));
			chk(32'(o_err_valid), 32'h0);
			@(posedge i_mclk);
			#1;
			chk(o_rate_live, rows[k].rate);
			chk(32'(o_rate_115200), 32'(rows[k].rate == 32'h7));
			$display("row %0d done", k);
		end
		i_host.put(8'h55);
		i_host.put(8'h13);
		i_host.frame(8'h09, 8'h21, `LPC_NAME_JOIN, 32'h0, 0, 8'h00);
		#1;
		chk(32'(o_rsp_valid), 32'h1);
		chk(o_rsp_value, 32'hff);
		$display("noise test done");
		i_host.frame(8'h09, 8'h22, `LPC_NAME_RATE, 32'h7, 1, 8'h01);
		#1;
		chk(32'(o_err_valid), 32'h1);
		chk(32'(o_err_status), 32'(`LPC_ST_BADCHK));
		$display("checksum test done");
		i_host.frame(8'h09, 8'h24, `LPC_NAME_JOIN, 32'h3c, 2, 8'h00);
		@(posedge i_mclk);
		#1;
		chk(o_join_live, 32'hff);
		i_host.frame(8'h08, 8'h25, `LPC_NAME_JOIN, 32'h0, 0, 8'h00);
		#1;
		chk(o_rsp_value, 32'hff);
		@(posedge i_mclk);
		#1;
		chk(o_join_live, 32'h3c);
		$display("join test done");
		i_host.put(`LPC_DELIM);
		i_host.put(8'h00);
		i_host.put(8'h20);
		i_host.idle();
		#1;
		chk(32'(o_err_valid), 32'h1);
		chk(32'(o_err_status), 32'(`LPC_ST_BADFRM));
		i_host.put(`LPC_DELIM);
		i_host.put(8'h00);
		i_host.put(8'h02);
		i_host.put(8'h08);
		i_host.put(8'h31);
		i_host.put(8'hc6);
		i_host.idle();
		#1;
		chk(32'(o_err_valid), 32'h1);
		chk(32'(o_err_status), 32'(`LPC_ST_BADFRM));
		$display("bad frame test done");
		i_host.frame(8'h09, 8'h26, 16'h4e44, 32'h5, 1, 8'h00);
		#1;
		chk(32'(o_rsp_status), 32'(`LPC_ST_BADNAME));
		@(posedge i_mclk);
		#1;
		chk(o_rate_live, 32'h3);
		$display("name test done");
		i_host.frame(8'h08, 8'h23, `LPC_NAME_RATE, 32'h7, 1, 8'h00);
		@(posedge i_mclk);
		#1;
		chk(o_rate_live, 32'h7);
		i_host.put(`LPC_DELIM);
		i_host.put(8'h00);
		i_nrst <= 1'b0;
		i_host.idle();
		#1;
		chk(o_rate_live, 32'h3);
		chk(o_join_live, 32'hff);
		@(posedge i_mclk);
		i_nrst <= 1'b1;
		repeat (2) begin
			@(posedge i_mclk);
			#1;
			chk(32'(o_rsp_valid | o_err_valid | o_other_frame), 32'h0);
		end
		i_host.frame(8'h09, 8'h27, `LPC_NAME_RATE, 32'h0, 0, 8'h00);
		#1;
		chk(o_rsp_value, 32'h3);
		$display("reset test done");
		final_report();
	end
endmodule // tb
bind lpc_cmd_frames lpc_chk i_chk (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_rx_valid(i_rx_valid),
	.o_rsp_valid(o_rsp_valid), .o_rsp_id(o_rsp_id), .o_rsp_type(o_rsp_type),
	.o_rsp_name(o_rsp_name), .o_err_valid(o_err_valid), .o_other_frame(o_other_frame),
	.o_rate_live(o_rate_live), .o_join_live(o_join_live), .o_rate_115200(o_rate_115200));
`default_nettype wire

// File: include/lpc_regs.vh
// Purpose: Constants for the local parameter command frame interpreter
// Assumes: Byte stream with one valid strobe per byte
// Notes:   Offsets are byte positions within a frame
`ifndef LPC_REGS_VH
`define LPC_REGS_VH
`define LPC_DELIM        8'h7e
`define LPC_CHK_GOOD     8'hff
`define LPC_TYPE_NOW     8'h08
`define LPC_TYPE_QUEUE   8'h09
`define LPC_OFS_TYPE     16'h0003
`define LPC_OFS_ID       16'h0004
`define LPC_OFS_NAME_HI  16'h0005
`define LPC_OFS_NAME_LO  16'h0006
`define LPC_OFS_PARAM    16'h0007
`define LPC_NAME_RATE    16'h4244
`define LPC_NAME_APPLY   16'h4143
`define LPC_NAME_JOIN    16'h4e4a
`define LPC_RATE_RESET   32'h00000003
`define LPC_JOIN_RESET   32'h000000ff
`define LPC_ST_OK        8'h00
`define LPC_ST_BADCHK    8'h01
`define LPC_ST_BADFRM    8'h02
`define LPC_ST_BADNAME   8'h03
`endif

// File: verilog/lpc_cmd_frames.v
// Purpose: Parses local parameter command frames and reports results
// Assumes: Unescaped frames, one byte per i_rx_valid pulse
// Notes:   Response is a one-cycle summary pulse, not a serial frame
// Function
// RULE_01: Frame opens with 0x7e, then two-byte length of bytes before checksum.
// RULE_02: Checksum is 0xff minus low byte sum from type to before checksum.
// RULE_03: Identifier at offset 4; identifier zero suppresses every response. Code gates only o_rsp_valid; o_err_valid status reports still fire.
// RULE_04: Host puts two ASCII name characters at offsets 5 and 6.
// RULE_05: Parameter bytes present means write; absent means read.
// RULE_06: Type 0x08 executes then applies all pending changes.
// RULE_07: Type 0x09 writes stay pending until 0x08 or apply command.
// RULE_08: Reads in queueing frames return the current value at once.
// RULE_09: One, two or four byte padded values mean the same value.
// RULE_10: Rate code 7 selects 115200; queued change keeps the old rate.
// RULE_11: Bytes before a start delimiter are dropped silently.
// RULE_12: Sum of bytes after length including checksum must be 0xff.
// RULE_13: Bad frame or checksum yields a status report giving the failure.
// RULE_14: Multi-byte fields travel most significant byte first.
// RULE_15: Response carries the identifier the host supplied.
// RULE_16: Other frame types are ignored here and alter no parameter.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_regs.vh"
module lpc_cmd_frames #(
	parameter MAX_LEN = 16
) (
	input  wire        i_mclk,
	input  wire        i_nrst,
	input  wire        i_rx_valid,
	input  wire [7:0]  i_rx_data,
	output wire        o_rsp_valid,
	output wire [7:0]  o_rsp_id,
	output wire [7:0]  o_rsp_type,
	output wire [15:0] o_rsp_name,
	output wire [7:0]  o_rsp_status,
	output wire [31:0] o_rsp_value,
	output wire        o_err_valid,
	output wire [7:0]  o_err_status,
	output wire        o_other_frame,
	output wire [31:0] o_rate_live,
	output wire [31:0] o_join_live,
	output wire        o_rate_115200
);
	localparam ST_IDLE = 3'd0;
	localparam ST_LENH = 3'd1;
	localparam ST_LENL = 3'd2;
	localparam ST_BODY = 3'd3;
	localparam ST_CHK  = 3'd4;

	reg [2:0]  state_r;
	reg [15:0] len_r;
	reg [15:0] cnt_r;
	reg [7:0]  sum_r;
	reg [7:0]  type_r;
	reg [7:0]  id_r;
	reg [15:0] name_r;
	reg [31:0] val_r;
	reg        rsp_v_r;
	reg [7:0]  rsp_id_r;
	reg [7:0]  rsp_type_r;
	reg [15:0] rsp_name_r;
	reg [7:0]  rsp_st_r;
	reg [31:0] rsp_val_r;
	reg        err_v_r;
	reg [7:0]  err_st_r;
	reg        other_r;
	reg        wr_r;
	reg        sel_rate_r;
	reg [31:0] wdata_r;
	reg        apply_r;

	wire [31:0] rate_pend;
	wire [31:0] join_pend;
	wire [7:0]  sum_nxt;
	wire        known_name;
	wire        is_write;
	wire        ours;

	assign sum_nxt = sum_r + i_rx_data;
	assign known_name = (name_r == `LPC_NAME_RATE) || (name_r == `LPC_NAME_JOIN) ||
		(name_r == `LPC_NAME_APPLY);
	assign is_write = (len_r > 16'h0004); // [RULE_05]
	assign ours = (type_r == `LPC_TYPE_NOW) || (type_r == `LPC_TYPE_QUEUE); // [RULE_16]

	function [31:0] live_of;
		input [15:0] nm;
		input [31:0] rl;
		input [31:0] jl;
		begin
			live_of = (nm == `LPC_NAME_RATE) ? rl : ((nm == `LPC_NAME_JOIN) ? jl : 32'h0);
		end
	endfunction

	lpc_param_bank u_bank (
		.i_mclk      (i_mclk),
		.i_nrst      (i_nrst),
		.i_wr        (wr_r),
		.i_sel_rate  (sel_rate_r),
		.i_wdata     (wdata_r),
		.i_apply     (apply_r),
		.o_rate_live (o_rate_live),
		.o_join_live (o_join_live),
		.o_rate_pend (rate_pend),
		.o_join_pend (join_pend)
	);

	always @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r    <= ST_IDLE;
			len_r      <= 16'h0;
			cnt_r      <= 16'h0;
			sum_r      <= 8'h0;
			type_r     <= 8'h0;
			id_r       <= 8'h0;
			name_r     <= 16'h0;
			val_r      <= 32'h0;
			rsp_v_r    <= 1'b0;
			rsp_id_r   <= 8'h0;
			rsp_type_r <= 8'h0;
			rsp_name_r <= 16'h0;
			rsp_st_r   <= 8'h0;
			rsp_val_r  <= 32'h0;
			err_v_r    <= 1'b0;
			err_st_r   <= 8'h0;
			other_r    <= 1'b0;
			wr_r       <= 1'b0;
			sel_rate_r <= 1'b0;
			wdata_r    <= 32'h0;
			apply_r    <= 1'b0;
		end else begin
			rsp_v_r <= 1'b0;
			err_v_r <= 1'b0;
			other_r <= 1'b0;
			wr_r    <= 1'b0;
			apply_r <= 1'b0;
			if (i_rx_valid) begin
				case (state_r)
				ST_IDLE: begin
					if (i_rx_data == `LPC_DELIM) begin // [RULE_01] [RULE_11]
						state_r <= ST_LENH;
					end
				end
				ST_LENH: begin
					len_r[15:8] <= i_rx_data; // [RULE_14]
					state_r     <= ST_LENL;
				end
				ST_LENL: begin
					len_r[7:0] <= i_rx_data;
					cnt_r      <= 16'h0;
					sum_r      <= 8'h0;
					val_r      <= 32'h0;
					if ({len_r[15:8], i_rx_data} == 16'h0 ||
					    {len_r[15:8], i_rx_data} > MAX_LEN[15:0]) begin
						err_v_r  <= 1'b1; // [RULE_13]
						err_st_r <= `LPC_ST_BADFRM;
						state_r  <= ST_IDLE;
					end else begin
						state_r <= ST_BODY;
					end
				end
				ST_BODY: begin
					sum_r <= sum_nxt; // [RULE_02] [RULE_12]
					cnt_r <= cnt_r + 16'h1;
					case (cnt_r + `LPC_OFS_TYPE)
					`LPC_OFS_TYPE:    type_r       <= i_rx_data;
					`LPC_OFS_ID:      id_r         <= i_rx_data; // [RULE_03]
					`LPC_OFS_NAME_HI: name_r[15:8] <= i_rx_data; // [RULE_04]
					`LPC_OFS_NAME_LO: name_r[7:0]  <= i_rx_data;
					default:          val_r <= {val_r[23:0], i_rx_data}; // [RULE_09] [RULE_14]
					endcase
					if (cnt_r + 16'h1 == len_r) begin
						state_r <= ST_CHK;
					end
				end
				ST_CHK: begin
					state_r <= ST_IDLE;
					if (sum_nxt != `LPC_CHK_GOOD) begin // [RULE_12]
						err_v_r  <= 1'b1; // [RULE_13]
						err_st_r <= `LPC_ST_BADCHK;
					end else if (!ours) begin
						other_r <= 1'b1; // [RULE_16]
					end else if (len_r < 16'h0004) begin
						err_v_r  <= 1'b1; // [RULE_13]
						err_st_r <= `LPC_ST_BADFRM;
					end else begin
						if (is_write && name_r != `LPC_NAME_APPLY &&
						    (name_r == `LPC_NAME_RATE || name_r == `LPC_NAME_JOIN)) begin
							wr_r       <= 1'b1;
							sel_rate_r <= (name_r == `LPC_NAME_RATE); // [RULE_10]
							wdata_r    <= val_r;
						end
						// Immediate type or apply command commits pending values
						apply_r <= (type_r == `LPC_TYPE_NOW) ||
							(name_r == `LPC_NAME_APPLY); // [RULE_06] [RULE_07]
						rsp_v_r    <= (id_r != 8'h00); // [RULE_03]
						rsp_id_r   <= id_r; // [RULE_15]
						rsp_type_r <= type_r;
						rsp_name_r <= name_r;
						rsp_st_r   <= known_name ? `LPC_ST_OK : `LPC_ST_BADNAME;
						rsp_val_r  <= is_write ? 32'h0 :
							live_of(name_r, o_rate_live, o_join_live); // [RULE_08]
					end
				end
				default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

	assign o_rsp_valid   = rsp_v_r;
	assign o_rsp_id      = rsp_id_r;
	assign o_rsp_type    = rsp_type_r;
	assign o_rsp_name    = rsp_name_r;
	assign o_rsp_status  = rsp_st_r;
	assign o_rsp_value   = rsp_val_r;
	assign o_err_valid   = err_v_r;
	assign o_err_status  = err_st_r;
	assign o_other_frame = other_r;
	assign o_rate_115200 = (o_rate_live == 32'h00000007); // [RULE_10]
endmodule // lpc_cmd_frames
`default_nettype wire

// File: verilog/lpc_param_bank.v
// Purpose: Holds live and pending copies of the local parameters
// Assumes: Write and apply strobes are one-cycle pulses
// Notes:   Apply copies every pending value into its live copy
`timescale 1ns/1ps
`default_nettype none
`include "lpc_regs.vh"
module lpc_param_bank (
	input  wire        i_mclk,
	input  wire        i_nrst,
	input  wire        i_wr,
	input  wire        i_sel_rate,
	input  wire [31:0] i_wdata,
	input  wire        i_apply,
	output wire [31:0] o_rate_live,
	output wire [31:0] o_join_live,
	output wire [31:0] o_rate_pend,
	output wire [31:0] o_join_pend
);
	reg [31:0] rate_live_r;
	reg [31:0] join_live_r;
	reg [31:0] rate_pend_r;
	reg [31:0] join_pend_r;
	wire [31:0] rate_pend_nxt;
	wire [31:0] join_pend_nxt;
	assign rate_pend_nxt = (i_wr && i_sel_rate) ? i_wdata : rate_pend_r;
	assign join_pend_nxt = (i_wr && !i_sel_rate) ? i_wdata : join_pend_r;
	always @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			rate_live_r <= `LPC_RATE_RESET;
			join_live_r <= `LPC_JOIN_RESET;
			rate_pend_r <= `LPC_RATE_RESET;
			join_pend_r <= `LPC_JOIN_RESET;
		end else begin
			rate_pend_r <= rate_pend_nxt;
			join_pend_r <= join_pend_nxt;
			// Live value moves only on apply [RULE_07] [RULE_10]
			if (i_apply) begin
				rate_live_r <= rate_pend_nxt;
				join_live_r <= join_pend_nxt;
			end
		end
	end
	assign o_rate_live = rate_live_r;
	assign o_join_live = join_live_r;
	assign o_rate_pend = rate_pend_r;
	assign o_join_pend = join_pend_r;
endmodule // lpc_param_bank
`default_nettype wire
